// ===== cama_dev.sv
// Cache end: memory-mapped access to the tag and data arrays
// Behaviour
// - F0 region tags, F1 region data, 16 MB
// - Longword only, no instruction fetch
// - Software uses regions only when privileged
// - Tag access: set 10-4, way 12-11
// - RAM mode folds way codes onto 0/1
// - Compare flag writes only the hitting way
// - Compare miss changes nothing
// - No compare: write set and way directly
// - Translate tag with MMU, store physical
// - Tag read returns tag, V, U, LRU
// - Invalidating dirty entry writes it back first
// - Software clears dirty when clearing valid
// - Line fill stores zero top tag bits
// - Software keeps top tag bits zero
// - Unused tag bits read zero, ignored
// - Data access: longword 3-2, region F1
// - Data access moves the selected longword
// - RAM mode: two cache ways, else four
// - Six LRU bits per set, readable, writable
//
// The implementer's own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module cama_dev (
   input  wire logic                 core_clk,
   input  wire logic                 rst,
   cama_if.dev                       bus,
   input  wire logic                 ram_mode_select,
   input  wire logic                 mmu_en,
   output logic                      xlat_req,
   output logic [cama_pkg::CAMA_TAG_W-1:0] xlat_va,
   input  wire logic                 xlat_ack,
   input  wire logic [cama_pkg::CAMA_TAG_W-1:0] xlat_pa,
   output logic                      wb_req,
   output logic [31:0]               wb_addr,
   output logic [127:0]              wb_line,
   input  wire logic                 wb_ack,
   output logic                      fill_ready,
   input  wire logic                 fill_valid,
   input  wire logic [cama_pkg::CAMA_SET_W-1:0] fill_set,
   input  wire logic [1:0]           fill_way,
   input  wire logic [cama_pkg::CAMA_TAG_W-1:0] fill_tag,
   input  wire logic [127:0]         fill_line
);
   import cama_pkg::*;

   typedef enum logic [4:0] {
      CAMA_IDLE = 5'b00001,
      CAMA_XLAT = 5'b00010,
      CAMA_EXEC = 5'b00100,
      CAMA_WB   = 5'b01000,
      CAMA_RESP = 5'b10000
   } cama_dev_state_t;

   typedef struct packed {
      cama_dev_state_t        st;
      logic                   wr;
      logic                   is_tag;
      logic                   acmp;
      logic [CAMA_SET_W-1:0]  set;
      logic [1:0]             way;
      logic [1:0]             lw;
      logic [31:0]            wdata;
      logic [CAMA_TAG_W-1:0]  tag;
      logic [31:0]            rdata;
      logic                   err;
   } cama_dev_regs_t;

   cama_dev_regs_t r_q, r_d;

   logic [CAMA_TAG_W-1:0] tag_mem [CAMA_SETS*CAMA_WAYS];
   logic                  vld_mem [CAMA_SETS*CAMA_WAYS];
   logic                  dty_mem [CAMA_SETS*CAMA_WAYS];
   logic [CAMA_LRU_W-1:0] lru_mem [CAMA_SETS];
   logic [31:0]           dat_mem [CAMA_SETS*CAMA_WAYS*CAMA_WORDS];

   logic                   tag_we;
   logic                   dat_we;
   logic [CAMA_ENT_W-1:0]  ent;
   logic [CAMA_DIDX_W-1:0] didx;
   logic                   need_wb;
   logic                   hit;
   logic [1:0]             hit_way;

   function automatic logic [1:0] map_way(input logic [1:0] code,
                                          input logic ram);
      map_way = ram ? {1'b0, code[0]} : code;
   endfunction

   function automatic logic [CAMA_ENT_W-1:0] ent_of(
      input logic [CAMA_SET_W-1:0] s, input logic [1:0] w);
      ent_of = {s, w};
   endfunction

   assign ent  = ent_of(r_q.set, r_q.way);
   assign didx = {ent, r_q.lw};
   assign need_wb = vld_mem[ent] & dty_mem[ent]
                    & ~r_q.wdata[CAMA_V_BIT];

   // Only cache ways take part in the compare; RAM ways hold no tags
   always_comb begin
      hit = 1'b0;
      hit_way = 2'h0;
      for (int w = 0; w < CAMA_WAYS; w++) begin
         if (!hit && (!ram_mode_select || w < 2) &&
             vld_mem[ent_of(r_q.set, 2'(w))] &&
             tag_mem[ent_of(r_q.set, 2'(w))] == r_q.tag) begin
            hit = 1'b1;
            hit_way = 2'(w);
         end
      end
   end

   always_comb begin
      r_d = r_q;
      tag_we = 1'b0;
      dat_we = 1'b0;
      case (r_q.st)
         CAMA_IDLE: begin
            // A fill in the same cycle goes first
            if (bus.req && !fill_valid) begin
               r_d.wr     = bus.wr;
               r_d.is_tag = bus.addr[CAMA_REGION_MSB:CAMA_REGION_LSB]
                            == CAMA_TAG_REGION;
               r_d.acmp   = bus.wr && bus.addr[CAMA_ACMP_BIT];
               r_d.set    = bus.addr[CAMA_SET_MSB:CAMA_SET_LSB];
               r_d.way    = map_way(bus.addr[CAMA_WAY_MSB:CAMA_WAY_LSB],
                                    ram_mode_select);
               r_d.lw     = bus.addr[CAMA_LW_MSB:CAMA_LW_LSB];
               r_d.wdata  = bus.wdata;
               r_d.tag    = bus.wdata[31:CAMA_TAG_LSB];
               r_d.rdata  = 32'h0000_0000;
               r_d.err    = 1'b0;
               if (bus.size != CAMA_SIZE_LONG || bus.ifetch ||
                   !bus.priv) begin
                  r_d.err = 1'b1;
                  r_d.st  = CAMA_RESP;
               end else if (bus.addr[CAMA_REGION_MSB:CAMA_REGION_LSB]
                            == CAMA_TAG_REGION) begin
                  r_d.st = (bus.wr && mmu_en) ? CAMA_XLAT
                                              : CAMA_EXEC;
               end else if (bus.addr[CAMA_REGION_MSB:CAMA_REGION_LSB]
                            == CAMA_DATA_REGION) begin
                  r_d.st = CAMA_EXEC;
               end else begin
                  r_d.err = 1'b1;
                  r_d.st  = CAMA_RESP;
               end
            end
         end
         CAMA_XLAT: begin
            if (xlat_ack) begin
               r_d.tag = xlat_pa;
               r_d.st  = CAMA_EXEC;
            end
         end
         CAMA_EXEC: begin
            if (!r_q.is_tag) begin
               if (r_q.wr) begin
                  dat_we = 1'b1;
               end else begin
                  r_d.rdata = dat_mem[didx];
               end
               r_d.st = CAMA_RESP;
            end else if (!r_q.wr) begin
               r_d.rdata = '0;
               r_d.rdata[31:CAMA_TAG_LSB] = tag_mem[ent];
               r_d.rdata[CAMA_LRU_LSB +: CAMA_LRU_W] =
                  lru_mem[r_q.set];
               r_d.rdata[CAMA_U_BIT] = dty_mem[ent];
               r_d.rdata[CAMA_V_BIT] = vld_mem[ent];
               r_d.st = CAMA_RESP;
            end else if (r_q.acmp) begin
               // Resolve the compare, then write as a direct access
               r_d.acmp = 1'b0;
               r_d.way  = hit_way;
               r_d.st   = hit ? CAMA_EXEC : CAMA_RESP;
            end else if (need_wb) begin
               r_d.st = CAMA_WB;
            end else begin
               tag_we = 1'b1;
               r_d.st = CAMA_RESP;
            end
         end
         CAMA_WB: begin
            if (wb_ack) begin
               tag_we = 1'b1;
               r_d.st = CAMA_RESP;
            end
         end
         CAMA_RESP: begin
            r_d.st = CAMA_IDLE;
         end
         default: begin
            r_d.st = CAMA_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         r_q <= '{st: CAMA_IDLE, way: 2'h0, lw: 2'h0, set: '0,
                  wdata: 32'h0000_0000, tag: '0, rdata: 32'h0000_0000,
                  default: 1'b0};
      end else begin
         r_q <= r_d;
      end
   end

   // Tag and data contents are not cleared by reset, only V, U and LRU
   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int i = 0; i < CAMA_SETS*CAMA_WAYS; i++) begin
            vld_mem[i] <= 1'b0;
            dty_mem[i] <= 1'b0;
         end
         for (int i = 0; i < CAMA_SETS; i++) begin
            lru_mem[i] <= CAMA_LRU_RST;
         end
      end else if (fill_valid && fill_ready) begin
         tag_mem[ent_of(fill_set, fill_way)] <=
            {{CAMA_SHADOW_W{1'b0}},
             fill_tag[CAMA_TAG_W-CAMA_SHADOW_W-1:0]};
         vld_mem[ent_of(fill_set, fill_way)] <= 1'b1;
         dty_mem[ent_of(fill_set, fill_way)] <= 1'b0;
         for (int k = 0; k < CAMA_WORDS; k++) begin
            dat_mem[{ent_of(fill_set, fill_way), 2'(k)}] <=
               fill_line[32*k +: 32];
         end
      end else if (tag_we) begin
         tag_mem[ent] <= r_q.tag;
         vld_mem[ent] <= r_q.wdata[CAMA_V_BIT];
         dty_mem[ent] <= r_q.wdata[CAMA_U_BIT];
         lru_mem[r_q.set] <=
            r_q.wdata[CAMA_LRU_LSB +: CAMA_LRU_W];
      end else if (dat_we) begin
         dat_mem[didx] <= r_q.wdata;
      end
   end

   assign bus.ack    = (r_q.st == CAMA_RESP);
   assign bus.rdata  = r_q.rdata;
   assign bus.err    = r_q.err;
   assign xlat_req   = (r_q.st == CAMA_XLAT);
   assign xlat_va    = r_q.tag;
   assign wb_req     = (r_q.st == CAMA_WB);
   // Tag bit 10 doubles as the set MSB, so only set bits 9-4 follow it
   assign wb_addr    = {tag_mem[ent], r_q.set[CAMA_SET_W-2:0], 4'h0};
   assign fill_ready = (r_q.st == CAMA_IDLE);

   always_comb begin
      wb_line = '0;
      for (int k = 0; k < CAMA_WORDS; k++) begin
         wb_line[32*k +: 32] = dat_mem[{ent, 2'(k)}];
      end
   end
endmodule

// ===== cama_pkg.sv
// Shared constants for the cache array access port
package cama_pkg;
   // Region decode
   localparam logic [7:0] CAMA_TAG_REGION  = 8'hF0;
   localparam logic [7:0] CAMA_DATA_REGION = 8'hF1;
   localparam int CAMA_REGION_MSB = 31;
   localparam int CAMA_REGION_LSB = 24;
   // Address fields
   localparam int CAMA_WAY_MSB = 12;
   localparam int CAMA_WAY_LSB = 11;
   localparam int CAMA_SET_MSB = 10;
   localparam int CAMA_SET_LSB = 4;
   localparam int CAMA_ACMP_BIT = 3;
   localparam int CAMA_LW_MSB = 3;
   localparam int CAMA_LW_LSB = 2;
   // Tag-array data word layout
   localparam int CAMA_TAG_LSB = 10;
   localparam int CAMA_TAG_W   = 22;
   localparam int CAMA_LRU_LSB = 4;
   localparam int CAMA_LRU_W   = 6;
   localparam int CAMA_U_BIT   = 1;
   localparam int CAMA_V_BIT   = 0;
   localparam int CAMA_SHADOW_W = 3;
   // Array geometry
   localparam int CAMA_SET_W  = 7;
   localparam int CAMA_SETS   = 128;
   localparam int CAMA_WAYS   = 4;
   localparam int CAMA_ENT_W  = 9;
   localparam int CAMA_DIDX_W = 11;
   localparam int CAMA_WORDS  = 4;
   localparam logic [5:0] CAMA_LRU_RST = 6'h00;
   // Access size code for a longword
   localparam logic [1:0] CAMA_SIZE_LONG = 2'h2;
   // Controller register word indices
   localparam logic [2:0] CAMA_REG_CMD    = 3'h0;
   localparam logic [2:0] CAMA_REG_ADDR   = 3'h1;
   localparam logic [2:0] CAMA_REG_WDATA  = 3'h2;
   localparam logic [2:0] CAMA_REG_RDATA  = 3'h3;
   localparam logic [2:0] CAMA_REG_STATUS = 3'h4;
   // Command register bits
   localparam int CAMA_CMD_GO    = 0;
   localparam int CAMA_CMD_WR    = 1;
   localparam int CAMA_CMD_PRIV  = 2;
   localparam int CAMA_CMD_FETCH = 3;
   localparam int CAMA_CMD_SZ_LSB = 4;
   // Status register bits
   localparam int CAMA_ST_BUSY = 0;
   localparam int CAMA_ST_ERR  = 1;
   localparam int CAMA_ST_DONE = 2;
endpackage

// ===== cama_if.sv
// Interface joining the CPU end and the cache array end
`timescale 1ns/1ps
interface cama_if;
   logic        req;
   logic        wr;
   logic [31:0] addr;
   logic [31:0] wdata;
   logic [1:0]  size;
   logic        priv;
   logic        ifetch;
   logic        ack;
   logic [31:0] rdata;
   logic        err;
   modport dev (input req, wr, addr, wdata, size, priv, ifetch,
                output ack, rdata, err);
   modport cpu (output req, wr, addr, wdata, size, priv, ifetch,
                input ack, rdata, err);
endinterface

// ===== cama_cpu.sv
// CPU end: issues array accesses ordered over Avalon-MM registers
`timescale 1ns/1ps
module cama_cpu (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic [2:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   cama_if.cpu              bus
);
   import cama_pkg::*;

   typedef struct packed {
      logic        busy;
      logic        wr;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [1:0]  size;
      logic        priv;
      logic        ifetch;
      logic [31:0] rdata;
      logic        err;
      logic        done;
   } cama_cpu_regs_t;

   cama_cpu_regs_t r_q, r_d;
   logic [31:0]    cmd;
   logic [31:0]    wd;

   assign cmd = avs_writedata;
   // A new command waits while one is in flight
   assign avs_waitrequest = avs_write && avs_address == CAMA_REG_CMD
                            && r_q.busy;

   always_comb begin
      r_d = r_q;
      wd  = r_q.wdata;
      if (r_q.busy && bus.ack) begin
         r_d.busy  = 1'b0;
         r_d.rdata = bus.rdata;
         r_d.err   = bus.err;
         r_d.done  = 1'b1;
      end
      if (avs_write && !avs_waitrequest) begin
         case (avs_address)
            CAMA_REG_ADDR:  r_d.addr  = avs_writedata;
            CAMA_REG_WDATA: r_d.wdata = avs_writedata;
            CAMA_REG_CMD: begin
               if (cmd[CAMA_CMD_GO]) begin
                  r_d.wr     = cmd[CAMA_CMD_WR];
                  r_d.priv   = cmd[CAMA_CMD_PRIV];
                  r_d.ifetch = cmd[CAMA_CMD_FETCH];
                  r_d.size   = cmd[CAMA_CMD_SZ_LSB +: 2];
                  r_d.done   = 1'b0;
                  r_d.err    = 1'b0;
                  if (cmd[CAMA_CMD_SZ_LSB +: 2] != CAMA_SIZE_LONG ||
                      cmd[CAMA_CMD_FETCH]) begin
                     r_d.err  = 1'b1;
                     r_d.done = 1'b1;
                  end else if (!cmd[CAMA_CMD_PRIV]) begin
                     r_d.err  = 1'b1;
                     r_d.done = 1'b1;
                  end else begin
                     r_d.busy = 1'b1;
                  end
                  if (cmd[CAMA_CMD_WR] &&
                      r_q.addr[CAMA_REGION_MSB:CAMA_REGION_LSB]
                      == CAMA_TAG_REGION) begin
                     wd[31 -: CAMA_SHADOW_W] = '0;
                     if (!wd[CAMA_V_BIT]) begin
                        wd[CAMA_U_BIT] = 1'b0;
                     end
                     r_d.wdata = wd;
                  end
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         r_q <= '{addr: 32'h0000_0000, wdata: 32'h0000_0000,
                  rdata: 32'h0000_0000, size: 2'h0, default: 1'b0};
      end else begin
         r_q <= r_d;
      end
   end

   // Read data only shows while a read is asked for
   always_comb begin
      avs_readdata = 32'h0000_0000;
      if (avs_read) begin
         case (avs_address)
            CAMA_REG_ADDR:   avs_readdata = r_q.addr;
            CAMA_REG_WDATA:  avs_readdata = r_q.wdata;
            CAMA_REG_RDATA:  avs_readdata = r_q.rdata;
            CAMA_REG_STATUS: avs_readdata = {29'h0, r_q.done, r_q.err,
                                             r_q.busy};
            default:         avs_readdata = 32'h0000_0000;
         endcase
      end
   end

   assign bus.req    = r_q.busy;
   assign bus.wr     = r_q.wr;
   assign bus.addr   = r_q.addr;
   assign bus.wdata  = r_q.wdata;
   assign bus.size   = r_q.size;
   assign bus.priv   = r_q.priv;
   assign bus.ifetch = r_q.ifetch;
endmodule

// ===== cama_properties.sv
// Link checks between the CPU end and the cache array end
`timescale 1ns/1ps
module cama_properties (
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic        req,
   input wire logic [31:0] addr,
   input wire logic [1:0]  size,
   input wire logic        priv,
   input wire logic        ifetch,
   input wire logic        wr,
   input wire logic        ack,
   input wire logic [31:0] rdata,
   input wire logic        err
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // F0 and F1 differ only in bit 24
   wire logic reg_ok = addr[31:25] == 7'h78;
   property p_ack_pulse;
      ack |=> !ack;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack held longer than one cycle");
   property p_err_size;
      ack && req && size != 2'h2 |-> err;
   endproperty
   a_err_size: assert property (p_err_size)
      else $error("non-longword access not refused");
   property p_err_fetch;
      ack && req && ifetch |-> err;
   endproperty
   a_err_fetch: assert property (p_err_fetch)
      else $error("instruction fetch not refused");
   property p_err_region;
      ack && req && !reg_ok |-> err;
   endproperty
   a_err_region: assert property (p_err_region)
      else $error("access outside both regions not refused");
   property p_ok_access;
      ack && req && reg_ok && size == 2'h2 && priv && !ifetch |-> !err;
   endproperty
   a_ok_access: assert property (p_ok_access)
      else $error("legal array access refused");
   property p_latency;
      $rose(req) |-> ##[1:64] ack;
   endproperty
   a_latency: assert property (p_latency)
      else $error("no answer to an array access");
   property p_unused_zero;
      ack && req && !wr && !err && addr[24] == 1'b0 |-> rdata[3:2] == 2'h0;
   endproperty
   a_unused_zero: assert property (p_unused_zero)
      else $error("unused tag bits read nonzero");
   property p_req_held;
      req && !ack |=> req && $stable(addr) && $stable(wr);
   endproperty
   a_req_held: assert property (p_req_held)
      else $error("request dropped before its answer");
endmodule

// ===== tb_top.sv
// Top bench: CPU end and cache end joined, driven over Avalon-MM
`timescale 1ns/1ps
module tb_top;
   import cama_pkg::*;
   logic         core_clk = 1'b0;
   logic         rst = 1'b1;
   logic [2:0]   avs_address = 3'h0;
   logic         avs_read = 1'b0;
   logic         avs_write = 1'b0;
   logic [31:0]  avs_writedata = 32'h0;
   logic [31:0]  avs_readdata, wb_addr, st, q, wb_a, wb_n = 32'h0;
   logic         avs_waitrequest, xlat_req, wb_req, fill_ready;
   logic         ram_mode_select = 1'b0;
   logic         mmu_en = 1'b0;
   logic         xlat_ack = 1'b0;
   logic         wb_ack = 1'b0;
   logic         fill_valid = 1'b0;
   logic [21:0]  xlat_va, xlat_pa = 22'h0, fill_tag = 22'h0;
   logic [6:0]   fill_set = 7'h0;
   logic [1:0]   fill_way = 2'h0;
   logic [127:0] wb_line, fill_line = 128'h0;
   int           miscompares = 0;
   int           checks_done = 0;
   int           cyc = 0;
   logic [31:0]  bad_a [4] = '{32'hF1000000, 32'hF1000000,
                               32'hF1000000, 32'hF2000000};
   logic [7:0]   bad_c [4] = '{8'h15, 8'h2D, 8'h21, 8'h25};
   cama_if bus_if ();
   cama_cpu u_cama_cpu (.core_clk(core_clk), .rst(rst),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .bus(bus_if.cpu));
   cama_dev u_cama_dev (.core_clk(core_clk), .rst(rst), .bus(bus_if.dev),
      .ram_mode_select(ram_mode_select), .mmu_en(mmu_en),
      .xlat_req(xlat_req), .xlat_va(xlat_va), .xlat_ack(xlat_ack),
      .xlat_pa(xlat_pa), .wb_req(wb_req), .wb_addr(wb_addr),
      .wb_line(wb_line), .wb_ack(wb_ack), .fill_ready(fill_ready),
      .fill_valid(fill_valid), .fill_set(fill_set), .fill_way(fill_way),
      .fill_tag(fill_tag), .fill_line(fill_line));
   cama_properties u_cama_properties (.core_clk(core_clk), .rst(rst),
      .req(bus_if.req), .addr(bus_if.addr), .size(bus_if.size),
      .priv(bus_if.priv), .ifetch(bus_if.ifetch), .wr(bus_if.wr),
      .ack(bus_if.ack), .rdata(bus_if.rdata), .err(bus_if.err));
   always #12.5 core_clk = ~core_clk;
   // Far side answers after one cycle; translation flips tag bit 0
   always @(posedge core_clk) begin
      xlat_ack <= xlat_req && !xlat_ack;
      xlat_pa <= xlat_va ^ 22'h1;
      wb_ack <= wb_req && !wb_ack;
      if (wb_req && wb_ack) begin
         wb_n = wb_n + 32'h1;
         wb_a = wb_addr;
      end
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         test_done;
      end
   end
   task automatic chk(input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One Avalon transfer, held until a rising edge sees waitrequest low
   task automatic av(input logic w, input logic [2:0] a,
                     input logic [31:0] d, output logic [31:0] r);
      @(posedge core_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      do begin
         @(posedge core_clk);
      end while (avs_waitrequest !== 1'b0);
      r = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic acc(input logic [31:0] a, d, input logic [7:0] c,
                      output logic [31:0] s, r);
      av(1'b1, CAMA_REG_ADDR, a, r);
      av(1'b1, CAMA_REG_WDATA, d, r);
      av(1'b1, CAMA_REG_CMD, {24'h0, c}, r);
      // Only the bench timeout ends a poll that never sees idle
      do begin
         av(1'b0, CAMA_REG_STATUS, 32'h0, s);
      end while (s[CAMA_ST_BUSY] !== 1'b0);
      av(1'b0, CAMA_REG_RDATA, 32'h0, r);
   endtask
   task automatic wr(input logic [31:0] a, d);
      acc(a, d, 8'h27, st, q);
      chk(st, 32'h4);
   endtask
   task automatic ld(input logic [31:0] a, exp);
      acc(a, 32'h0, 8'h25, st, q);
      chk(q, exp);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      for (int i = 0; i < 4; i++)
         wr(32'hF1001870 | (i << 2), 32'hD0C00000 + i);
      // Ignored address bits set on read-back
      for (int i = 0; i < 4; i++)
         ld(32'hF1FFF873 | (i << 2), 32'hD0C00000 + i);
      $display("data array test done");
      wr(32'hF0001010, 32'h12345ABF);
      ld(32'hF0001010, 32'h12345AB3);
      $display("tag direct test done");
      wr(32'hF0001050, 32'h01100003);
      wr(32'hF0000058, 32'h02200000);
      ld(32'hF0001050, 32'h01100003);
      chk(wb_n, 32'h0);
      wr(32'hF0000058, 32'h01100000);
      chk(wb_n, 32'h1);
      chk(wb_a, 32'h01100050);
      ld(32'hF0001050, 32'h01100000);
      $display("compare test done");
      foreach (bad_a[i]) begin
         acc(bad_a[i], 32'h0, bad_c[i], st, q);
         chk(st, 32'h6);
      end
      $display("refusal test done");
      mmu_en <= 1'b1;
      wr(32'hF0000940, 32'h04400001);
      ld(32'hF0000940, 32'h04400401);
      mmu_en <= 1'b0;
      ram_mode_select <= 1'b1;
      wr(32'hF1001090, 32'hA5A50F0F);
      ld(32'hF1000090, 32'hA5A50F0F);
      ram_mode_select <= 1'b0;
      $display("mode test done");
      // Line fill with all tag bits set; dev is idle here
      @(posedge core_clk);
      fill_valid <= 1'b1;
      fill_set <= 7'h1E;
      fill_tag <= 22'h3FFFFF;
      fill_line <= {4{32'h600DF00D}};
      @(posedge core_clk);
      fill_valid <= 1'b0;
      ld(32'hF00001E0, 32'h1FFFFC01);
      ld(32'hF10001E4, 32'h600DF00D);
      $display("fill test done");
      test_done;
   end
endmodule
